// ---- pkg/switch_fault_params.svh ----
// Constants of the switch fault block: offsets, field positions,
// reset values and timing. Assumes a 20 MHz clock and byte addresses.
`ifndef SWITCH_FAULT_PARAMS_SVH
`define SWITCH_FAULT_PARAMS_SVH
// Register byte offsets.
`define ADR_CONFIG 8'h00
`define ADR_SENSE 8'h04
`define ADR_STATUS 8'h08
`define ADR_LIVE 8'h0c
// Configuration word fields, four bits each.
`define CFG_CMD_LSB 0
`define CFG_SHORT_DIS_LSB 4
`define CFG_OFFOL_DIS_LSB 8
`define CFG_ONOL_DIS_LSB 12
`define CFG_LED_LSB 16
`define CFG_RATIO_LSB 20
// Sense and global word fields.
`define SNS_TEMP_EN_BIT 0
`define SNS_CUR_EN_BIT 1
`define SNS_CHAN_LSB 2
`define SNS_PWM_EN_BIT 4
`define SNS_VDD_FAIL_EN_BIT 5
// Status word fields.
`define ST_SHORT_LSB 0
`define ST_OFFOL_LSB 4
`define ST_ONOL_LSB 8
`define ST_PREWARN_BIT 12
`define ST_UNDER_BIT 13
// Live condition word fields.
`define LV_SHORT_LSB 0
`define LV_OFFOL_LSB 4
`define LV_OUT_LSB 8
`define LV_FAILSAFE_BIT 12
// Reset values.
`define CONFIG_RESET 4'h0
`define FAULT_PIN_RESET 1'b1
// Periodic LED open-load interval.
`define LED_LOAD_SELECT_TIME_US 1000
`define CLK_MHZ 20
`endif

// ---- pkg/switch_fault_pkg.sv ----
// Types of the switch fault block.
// Assumes the constants header is compiled alongside.
package switch_fault_pkg;
    typedef struct packed {
        logic [3:0] out_cmd;
        logic [3:0] short_dis;
        logic [3:0] offol_dis;
        logic [3:0] onol_dis;
        logic [3:0] led_sel;
        logic [3:0] ratio_sel;
        logic temp_en;
        logic cur_en;
        logic [1:0] chan;
        logic pwm_en;
        logic vdd_fail_en;
        logic [3:0] short_flag;
        logic [3:0] offol_flag;
        logic [3:0] onol_flag;
        logic prewarn_flag;
        logic under_flag;
        logic [23:0] timer;
        logic [3:0] on_seen;
        logic ack;
        logic [31:0] dat;
        logic [3:0] outs;
        logic fault_n;
        logic sense_on;
        logic [1:0] sense_chan;
        logic sense_ratio;
        logic temp_fb;
    } sfd_state_t;
endpackage

// ---- tb/sfd_load_model.sv ----
// Load and comparator model standing behind the switch outputs.
// Assumes the bench changes its fault masks right after clock edges.
`timescale 1ns/1ps
`default_nettype none
module sfd_load_model (
    input wire logic [3:0] outs_i,
    input wire logic [3:0] short_i,
    input wire logic [3:0] open_i,
    input wire logic [3:0] dim_i,
    input wire logic [3:0] overload_i,
    output logic [3:0] short_detect_o,
    output logic [3:0] gate_off_o,
    output logic [3:0] open_off_detect_o,
    output logic [3:0] below_bulb_o,
    output logic [3:0] below_led_o,
    output logic [3:0] overload_off_o
);
    // A shorted pin reads high in any state; the pull-up lifts only an
    // off pin. A dim load passes the LED threshold but not the bulb one.
    assign short_detect_o = short_i;
    assign gate_off_o = ~outs_i;
    assign open_off_detect_o = (short_i | open_i) & ~outs_i;
    assign below_bulb_o = (open_i | dim_i) & outs_i;
    assign below_led_o = open_i & outs_i;
    // The bench marks which outputs have an overload turn-off pending.
    assign overload_off_o = overload_i;
endmodule
`default_nettype wire

// ---- tb/switch_fault_chk.sv ----
// Port checker of the switch fault block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module switch_fault_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [3:0] direct_in_i,
    input wire logic [3:0] short_detect_i,
    input wire logic [3:0] open_off_detect_i,
    input wire logic [3:0] overload_off_i,
    input wire logic clamp_i,
    input wire logic logic_supply_ok_i,
    input wire logic battery_supply_ok_i,
    input wire logic [3:0] switch_outputs_o,
    input wire logic fault_pin_n_o,
    input wire logic sense_output_o,
    input wire logic [1:0] sense_channel_select_o,
    input wire logic temp_feedback_o
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A taken request gets exactly one ack pulse on the next edge.
    bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    // With no live short or open load the pin must read high.
    pin_idle_a: assert property (
        !(|short_detect_i) && !(|open_off_detect_i) |=> fault_pin_n_o)
        else $error("fault pin low with no fault");
    clamp_on_a: assert property (
        clamp_i && battery_supply_ok_i |=> switch_outputs_o == 4'hf)
        else $error("clamp left an output off");
    // The wipe lands one edge late, so one fail-safe cycle comes first.
    safe_drive_a: assert property (
        !logic_supply_ok_i && !$past(logic_supply_ok_i) && !clamp_i
        && battery_supply_ok_i && overload_off_i == 4'h0
        |=> switch_outputs_o == $past(direct_in_i))
        else $error("direct inputs not driving outputs");
    safe_sense_a: assert property (
        !logic_supply_ok_i |=> !sense_output_o)
        else $error("sense active in fail-safe");
    sense_on_a: assert property (
        sense_output_o |-> switch_outputs_o[sense_channel_select_o])
        else $error("sense with its switch off");
    temp_route_a: assert property (
        temp_feedback_o |-> !sense_output_o)
        else $error("temperature and current both routed");
    // Main scenarios reached.
    cover property (clamp_i);
    cover property (!logic_supply_ok_i && |direct_in_i);
    cover property (ack_o && !fault_pin_n_o);
    cover property (clamp_i && |overload_off_i);
endmodule
bind switch_fault_diagnostics switch_fault_chk u_switch_fault_chk (
    .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .direct_in_i, .short_detect_i,
    .open_off_detect_i, .clamp_i, .logic_supply_ok_i, .battery_supply_ok_i,
    .switch_outputs_o, .fault_pin_n_o, .sense_output_o, .temp_feedback_o,
    .overload_off_i, .sense_channel_select_o);
`default_nettype wire

// ---- tb/switch_fault_diagnostics_tb.sv ----
// Self-checking bench of the switch fault block and its load model.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "switch_fault_params.svh"
module switch_fault_diagnostics_tb;
    localparam logic [7:0] CF = `ADR_CONFIG;
    localparam logic [7:0] SN = `ADR_SENSE;
    localparam logic [7:0] ST = `ADR_STATUS;
    localparam logic [7:0] LV = `ADR_LIVE;
    // Supply word: por, logic fail, battery ok, logic ok, clamp, prewarn.
    localparam logic [5:0] OK = 6'b001100;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0, din = 0, sf = 0, of = 0, dim = 0, ovl = 0;
    logic [31:0] dat = 0, dat_o;
    logic [5:0] ctl = OK;
    logic ack_o, fault_n, sns, rto, tfb;
    logic [1:0] chan;
    logic [3:0] outs, sd, go, ood, bb, bl, ov;
    logic [31:0] exp_q[$], msk_q[$];
    int failures = 0, n_checks = 0;
    integer seed = 32'h06adcd2e;
    switch_fault_diagnostics #(.LED_LOAD_SELECT_CYCLES(8)) u_switch_fault_diagnostics (
        .clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o, .ack_o, .direct_in_i(din),
        .short_detect_i(sd), .gate_off_i(go), .open_off_detect_i(ood),
        .below_bulb_i(bb), .below_led_i(bl), .overload_off_i(ov),
        .temp_prewarn_i(ctl[0]), .clamp_i(ctl[1]),
        .logic_supply_ok_i(ctl[2]), .battery_supply_ok_i(ctl[3]),
        .logic_supply_fail_i(ctl[4]), .por_i(ctl[5]),
        .switch_outputs_o(outs), .fault_pin_n_o(fault_n),
        .sense_output_o(sns), .sense_channel_select_o(chan),
        .sense_ratio_select_o(rto), .temp_feedback_o(tfb));
    sfd_load_model u_sfd_load_model (.outs_i(outs), .short_i(sf),
        .open_i(of), .dim_i(dim), .short_detect_o(sd), .gate_off_o(go),
        .open_off_detect_o(ood), .below_bulb_o(bb), .below_led_o(bl),
        .overload_off_o(ov), .overload_i(ovl));
    initial forever #25 clk_i = ~clk_i;
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            failures++;
            $display("Error %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // A bus cycle notes its expectation before it starts; a zero mask
    // means nothing of the answer is compared.
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [31:0] m,
            input logic [3:0] s = 4'hf);
        exp_q.push_back(d);
        msk_q.push_back(m);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= w ? d : 32'h0;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1, a, d, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(0, a, e, 32'hffffffff);
    endtask
    task automatic inj(input logic [3:0] s, input logic [3:0] o,
            input logic [3:0] d);
        sf <= s;
        of <= o;
        dim <= d;
        tick(3);
    endtask
    task automatic hold(input logic [5:0] v, input int n);
        ctl <= v;
        tick(n);
        ctl <= OK;
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Each answer is matched against the oldest note of the driver.
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && exp_q.size() != 0) begin
            if (msk_q[0] != 0)
                chk(dat_o & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    // A hang costs a mismatch; the full run needs well under this.
    initial begin
        tick(5000);
        failures++;
        end_sim;
    end
    // ****
    // Scenarios
    // ****
    initial begin
        tick(2);
        rst_i <= 0;
        rd(CF, 0);
        rd(LV, 0);
        rd(8'h40, 0);
        wb(1, CF, 32'h00ff00ff, 0, 4'h1);
        rd(CF, 0);
        wb(1, CF, 32'h00ff00ff, 0, 4'h3);
        rd(CF, 32'h000000ff);
        wr(CF, 0);
        $display("test bus done");
        inj(4'h1, 0, 0);
        chk(32'(fault_n), 0);
        rd(ST, 32'h11);
        rd(ST, 32'h11);
        inj(0, 0, 0);
        chk(32'(fault_n), 1);
        rd(ST, 32'h11);
        rd(ST, 0);
        wr(CF, 32'h330);
        inj(4'h1, 4'h2, 0);
        chk(32'(fault_n), 1);
        rd(ST, 0);
        wr(CF, 32'h3);
        tick(3);
        chk(32'(fault_n), 1);
        rd(ST, 32'h200);
        rd(LV, 32'h300);
        inj(0, 0, 0);
        wr(CF, 0);
        rd(ST, 32'h200);
        rd(ST, 0);
        $display("test short done");
        inj(0, 4'h2, 0);
        chk(32'(fault_n), 0);
        rd(ST, 32'h20);
        inj(0, 0, 0);
        rd(ST, 32'h20);
        rd(ST, 0);
        $display("test off load done");
        wr(CF, 32'h4004);
        inj(0, 0, 4'h4);
        rd(ST, 0);
        wr(CF, 32'h40004);
        tick(20);
        rd(ST, 0);
        inj(0, 4'h4, 4'h4);
        tick(20);
        rd(ST, 0);
        wr(SN, 32'h10);
        tick(20);
        rd(ST, 32'h400);
        inj(0, 0, 0);
        wb(0, ST, 0, 0);
        rd(ST, 0);
        $display("test on load done");
        wr(CF, 32'h400004);
        wr(SN, 32'h1a);
        tick(3);
        chk({27'h0, rto, chan, sns, tfb}, 32'h1a);
        wr(CF, 32'h400000);
        tick(3);
        chk(32'(sns), 0);
        wr(SN, 32'h1);
        tick(3);
        chk(32'(tfb), 1);
        wr(CF, 32'h4);
        wr(SN, 32'ha);
        ctl <= 6'b001000;
        repeat (6) begin
            din <= 4'($random(seed));
            tick(3);
            chk(32'(outs), 32'(din));
            chk(32'(sns), 0);
        end
        ctl <= OK;
        din <= 0;
        rd(CF, 0);
        $display("test sense done");
        wr(CF, 32'h1);
        hold(6'b011100, 2);
        rd(CF, 32'h1);
        hold(6'b000100, 3);
        rd(ST, 32'h2000);
        rd(CF, 32'h1);
        hold(6'b001101, 1);
        rd(ST, 32'h1000);
        rd(ST, 0);
        wr(SN, 32'h20);
        hold(6'b011100, 2);
        rd(SN, 0);
        rd(CF, 0);
        $display("test supply done");
        ovl <= 4'hf;
        din <= 4'hf;
        ctl <= 6'b001110;
        tick(2);
        chk(32'(outs), 32'hf);
        ctl <= OK;
        tick(2);
        chk(32'(outs), 0);
        ovl <= 0;
        din <= 0;
        wr(CF, 32'h1);
        hold(6'b001101, 1);
        tick(1);
        hold(6'b101100, 2);
        rd(CF, 0);
        rd(ST, 0);
        $display("test clamp and power-on done");
        tick(2);
        end_sim;
    end
endmodule
`default_nettype wire

// ---- verilog/switch_fault_diagnostics.sv ----
// Fault diagnostics and supply-loss logic of a four-channel high-side
// switch, with its registers on a classic Wishbone slave.
// Assumes analog comparators arrive as inputs synchronous to clk_i.
// Analog thresholds, overcurrent and retry logic live outside this block;
// their results reach it only through the comparator and overload inputs.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "switch_fault_params.svh"

module switch_fault_diagnostics
    import switch_fault_pkg::*;
#(
    parameter int LED_LOAD_SELECT_CYCLES = `LED_LOAD_SELECT_TIME_US * `CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Direct commands and comparator results from the analog side.
    input wire logic [3:0] direct_in_i,
    input wire logic [3:0] short_detect_i,
    input wire logic [3:0] gate_off_i,
    input wire logic [3:0] open_off_detect_i,
    input wire logic [3:0] below_bulb_i,
    input wire logic [3:0] below_led_i,
    input wire logic [3:0] overload_off_i,
    // Temperature, clamp and supply monitors.
    input wire logic temp_prewarn_i,
    input wire logic clamp_i,
    input wire logic logic_supply_ok_i,
    input wire logic logic_supply_fail_i,
    input wire logic battery_supply_ok_i,
    input wire logic por_i,
    // Switch commands and sense routing.
    output logic [3:0] switch_outputs_o,
    output logic fault_pin_n_o,
    output logic sense_output_o,
    output logic [1:0] sense_channel_select_o,
    output logic sense_ratio_select_o,
    output logic temp_feedback_o
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************

    // The interval timer is 24 bits wide.
    // A zero interval would leave the LED test without a tick.
    if (LED_LOAD_SELECT_CYCLES < 1 || LED_LOAD_SELECT_CYCLES > 16777215) begin : g_bad
        $error("LED_LOAD_SELECT_CYCLES out of range");
    end

    // The timer counts 0 to TIMER_LAST, so one interval is LED_LOAD_SELECT_CYCLES.
    localparam logic [23:0] TIMER_LAST = 24'(LED_LOAD_SELECT_CYCLES - 1);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Clear-on-read flag update: a fresh set always wins, and a flag
    // whose condition is still live survives the read.
    // The live mask ties each flag to its own clearing rule: the short
    // uses its live condition, off open-load the fault pin.
    function automatic logic [3:0] keep_flags(
        input logic [3:0] flag,
        input logic [3:0] set,
        input logic [3:0] live,
        input logic rd
    );
        keep_flags = set | (flag & live) | (flag & {4{~rd}});
    endfunction

    // Only whole 16-bit halves form a valid message.
    // A single byte or three bytes would be a torn message, which is
    // answered on the bus but changes nothing.
    function automatic logic whole_words(input logic [3:0] sel);
        whole_words = (sel == 4'b0011) || (sel == 4'b1100) ||
                      (sel == 4'b1111);
    endfunction

    // Byte-lane merge of a write into an old word.
    // Lanes that are not enabled keep their old contents.
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wr,
        input logic [3:0] sel
    );
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                merge[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************

    // The whole block state is one registered struct; next_s is its
    // combinational next value, written by the process below.
    sfd_state_t s;
    sfd_state_t next_s;

    // Combinational views shared by the processes below.
    logic fail_safe;
    logic wipe;
    logic take;
    logic wr;
    logic rd_status;
    logic tick;
    logic [3:0] on_cmd;
    logic [3:0] short_live;
    logic [3:0] offol_live;
    logic [3:0] onol_live;
    logic [3:0] onol_set;
    logic [3:0] gated_off;
    // Register images as seen on the bus.
    logic [31:0] cfg_word;
    logic [31:0] sns_word;
    logic [31:0] st_word;
    logic [31:0] lv_word;
    logic [31:0] new_word;

    // Word views of the registers, also used for write merging.
    always_comb begin
        cfg_word = '0;
        cfg_word[`CFG_CMD_LSB +: 4] = s.out_cmd;
        cfg_word[`CFG_SHORT_DIS_LSB +: 4] = s.short_dis;
        cfg_word[`CFG_OFFOL_DIS_LSB +: 4] = s.offol_dis;
        cfg_word[`CFG_ONOL_DIS_LSB +: 4] = s.onol_dis;
        cfg_word[`CFG_LED_LSB +: 4] = s.led_sel;
        cfg_word[`CFG_RATIO_LSB +: 4] = s.ratio_sel;
        // Sense and global settings.
        sns_word = '0;
        sns_word[`SNS_TEMP_EN_BIT] = s.temp_en;
        sns_word[`SNS_CUR_EN_BIT] = s.cur_en;
        sns_word[`SNS_CHAN_LSB +: 2] = s.chan;
        sns_word[`SNS_PWM_EN_BIT] = s.pwm_en;
        sns_word[`SNS_VDD_FAIL_EN_BIT] = s.vdd_fail_en;
        // Latched faults; a status read clears those whose condition is no longer live.
        st_word = '0;
        st_word[`ST_SHORT_LSB +: 4] = s.short_flag;
        st_word[`ST_OFFOL_LSB +: 4] = s.offol_flag;
        st_word[`ST_ONOL_LSB +: 4] = s.onol_flag;
        st_word[`ST_PREWARN_BIT] = s.prewarn_flag;
        st_word[`ST_UNDER_BIT] = s.under_flag;
        // Live conditions, read only and never latched.
        lv_word = '0;
        lv_word[`LV_SHORT_LSB +: 4] = short_live;
        lv_word[`LV_OFFOL_LSB +: 4] = offol_live;
        lv_word[`LV_OUT_LSB +: 4] = s.outs;
        lv_word[`LV_FAILSAFE_BIT] = fail_safe;
    end

    // Live fault conditions. Direct inputs and the on bit both command
    // an output on, so either masks the off-state checks.
    always_comb begin
        // Losing the logic supply is fail-safe mode; the wipe repeats every
        // cycle the cause lasts, so nothing written then survives.
        fail_safe = ~logic_supply_ok_i;
        wipe = por_i | fail_safe |
               (logic_supply_fail_i & s.vdd_fail_en);
        on_cmd = s.out_cmd | direct_in_i;
        // Off-state checks run only on outputs that nothing commands on.
        short_live = ~on_cmd & short_detect_i & ~s.short_dis;
        offol_live = ~on_cmd & open_off_detect_i & ~s.offol_dis;
        // The gate input says the output has really gone off.
        gated_off = gate_off_i & ~on_cmd;
        // LED loads use the LED threshold, bulbs the bulb one.
        onol_live = s.outs & ~s.onol_dis &
                    ((s.led_sel & below_led_i) |
                     (~s.led_sel & below_bulb_i));
        // The interval tick paces the LED open-load test.
        tick = (s.timer == TIMER_LAST);
        // Bulbs are tested all the time; LEDs only at the interval tick
        // after a whole interval on with the PWM module enabled.
        onol_set = onol_live & (~s.led_sel |
                   ({4{tick & s.pwm_en}} & s.on_seen));
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    // A request is taken on the edge that sees it with ack low.
    // Reads and writes both answer in one cycle, so the master never
    // waits longer than one edge; ack high between requests blocks a
    // second take of the same request.
    always_comb begin
        take = cyc_i & stb_i & ~s.ack;
        wr = take & we_i & whole_words(sel_i);
        // Of the bus reads, only a read of the status word clears latched flags; the live
        // word can be polled freely.
        rd_status = take & ~we_i & (adr_i == `ADR_STATUS);
        // Only the two writable words have a merge image.
        new_word = '0;
        if (adr_i == `ADR_CONFIG) begin
            new_word = merge(cfg_word, dat_i, sel_i);
        end else if (adr_i == `ADR_SENSE) begin
            new_word = merge(sns_word, dat_i, sel_i);
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    always_comb begin
        // Start from the held state; each group below updates its part.
        next_s = s;
        // Single-cycle answer; unmapped addresses read as zero.
        next_s.ack = take;
        // Read data is zero outside the answer cycle, so no stale word shows.
        next_s.dat = '0;
        if (take & ~we_i) begin
            if (adr_i == `ADR_CONFIG) begin
                next_s.dat = cfg_word;
            end else if (adr_i == `ADR_SENSE) begin
                next_s.dat = sns_word;
            end else if (adr_i == `ADR_STATUS) begin
                next_s.dat = st_word;
            end else if (adr_i == `ADR_LIVE) begin
                next_s.dat = lv_word;
            end
        end

        // Configuration writes.
        if (wr && adr_i == `ADR_CONFIG) begin
            next_s.out_cmd = new_word[`CFG_CMD_LSB +: 4];
            next_s.short_dis = new_word[`CFG_SHORT_DIS_LSB +: 4];
            next_s.offol_dis = new_word[`CFG_OFFOL_DIS_LSB +: 4];
            next_s.onol_dis = new_word[`CFG_ONOL_DIS_LSB +: 4];
            next_s.led_sel = new_word[`CFG_LED_LSB +: 4];
            next_s.ratio_sel = new_word[`CFG_RATIO_LSB +: 4];
        end else if (wr && adr_i == `ADR_SENSE) begin
            next_s.temp_en = new_word[`SNS_TEMP_EN_BIT];
            next_s.cur_en = new_word[`SNS_CUR_EN_BIT];
            next_s.chan = new_word[`SNS_CHAN_LSB +: 2];
            next_s.pwm_en = new_word[`SNS_PWM_EN_BIT];
            next_s.vdd_fail_en = new_word[`SNS_VDD_FAIL_EN_BIT];
        end

        // Short latches only once the gate has really pulled the output
        // off, and marks off open-load too. The open-load flag stays
        // while the fault pin is low.
        next_s.short_flag = keep_flags(s.short_flag,
            short_live & gated_off, short_live, rd_status);
        // A shorted output also reads high, so it marks off open-load too.
        next_s.offol_flag = keep_flags(s.offol_flag,
            (short_live | offol_live) & gated_off,
            {4{~s.fault_n}}, rd_status);
        // The on open-load flag never touches the fault pin.
        next_s.onol_flag = keep_flags(s.onol_flag, onol_set,
            onol_live, rd_status);

        // Prewarning only in normal mode; only a read or a wipe clears it.
        next_s.prewarn_flag = (temp_prewarn_i & ~fail_safe) |
            (s.prewarn_flag & ~rd_status);
        // Battery loss keeps configuration and is reported; unclamped outputs go off.
        // The flag re-sets every cycle while the battery stays bad.
        next_s.under_flag = (~battery_supply_ok_i) |
            (s.under_flag & ~rd_status);

        // Interval timer and the whole-interval-on marks.
        // A mark set at one tick lets the LED test run at the next, so the
        // output has been on for at least a whole interval when tested.
        next_s.timer = tick ? 24'h000000 : s.timer + 24'h000001;
        for (int i = 0; i < 4; i++) begin
            if (!s.outs[i]) begin
                next_s.on_seen[i] = 1'b0;
            end else if (tick) begin
                next_s.on_seen[i] = 1'b1;
            end
        end

        // Logic supply loss or power-on reset wipes configuration and latched faults.
        // Placed after the flag updates so a wipe beats a set in one cycle.
        if (wipe) begin
            next_s.out_cmd = `CONFIG_RESET;
            next_s.short_dis = `CONFIG_RESET;
            next_s.offol_dis = `CONFIG_RESET;
            next_s.onol_dis = `CONFIG_RESET;
            next_s.led_sel = `CONFIG_RESET;
            next_s.ratio_sel = `CONFIG_RESET;
            next_s.temp_en = 1'b0;
            next_s.cur_en = 1'b0;
            next_s.chan = 2'b00;
            next_s.pwm_en = 1'b0;
            next_s.vdd_fail_en = 1'b0;
            next_s.short_flag = 4'h0;
            next_s.offol_flag = 4'h0;
            next_s.onol_flag = 4'h0;
            next_s.prewarn_flag = 1'b0;
            next_s.under_flag = 1'b0;
        end

        // Outputs: the clamp overrides any overload turn-off and turns
        // every switch on; otherwise a valid battery is needed.
        if (clamp_i) begin
            next_s.outs = 4'hf;
        end else begin
            next_s.outs = on_cmd & ~overload_off_i &
                          {4{battery_supply_ok_i}};
        end

        // Pin reports live conditions; on open-load never touches it.
        next_s.fault_n = ~|(short_live | offol_live);

        // Sense routing.
        // The sense enable looks at next_s.outs so sense and switch change
        // on the same edge and sense never leads its switch.
        next_s.sense_chan = s.chan;
        next_s.sense_ratio = s.ratio_sel[s.chan];
        next_s.temp_fb = s.temp_en & ~s.cur_en;
        next_s.sense_on = s.cur_en & ~fail_safe &
                          next_s.outs[s.chan];

        // Synchronous reset overrides everything else.
        if (rst_i) begin
            next_s = '0;
            next_s.fault_n = `FAULT_PIN_RESET;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // One register bank; every output is a flip-flop of it.
    // Reset is folded into next_s, so this process stays a plain
    // register with no branch of its own.
    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    // Outputs are fields of the register, so none has logic after it.
    assign dat_o = s.dat;
    assign ack_o = s.ack;
    assign switch_outputs_o = s.outs;
    assign fault_pin_n_o = s.fault_n;
    assign sense_output_o = s.sense_on;
    assign sense_channel_select_o = s.sense_chan;
    assign sense_ratio_select_o = s.sense_ratio;
    assign temp_feedback_o = s.temp_fb;

endmodule
`default_nettype wire
